// ===== testbench/hrc_host_mdl.sv
// Purpose: Host bus model driving chip enable, strobes and data bit zero
// Assumes: Enable phase lasts nine clocks, release at least eleven, so the synchroniser settles
// Notes:   A released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module hrc_host_mdl (
	// Clock
	input  wire logic i_sys_clk,
	// Memory side
	input  wire logic i_mem_n,
	input  wire logic i_d0,
	// Host pins
	output logic      o_ce_n,
	output logic      o_oe_n,
	output logic      o_we_n,
	output logic      o_d0
);
	logic q;

	initial begin
		o_ce_n = 1'b1;
		o_oe_n = 1'b1;
		o_we_n = 1'b1;
		o_d0   = 1'b0;
	end

	// ------------------------------------------------------------
	// One host cycle, memory enable sampled mid-cycle
	// ------------------------------------------------------------
	task automatic cyc(input logic wr, input logic d, output logic mem);
		@(posedge i_sys_clk);
		o_ce_n <= 1'b0;
		o_oe_n <= wr;
		o_we_n <= !wr;
		o_d0   <= d;
		repeat (9) @(posedge i_sys_clk);
		mem = i_mem_n;
		q   = i_d0;
		o_ce_n <= 1'b1;
		o_oe_n <= 1'b1;
		o_we_n <= 1'b1;
		o_d0   <= !d;
		repeat (10) @(posedge i_sys_clk);
	endtask

	// ------------------------------------------------------------
	// Pointer reset by a read, then pattern bits LSB first
	// ------------------------------------------------------------
	task automatic unlock(input logic [63:0] pat, output logic ok);
		logic m;
		ok = 1'b1;
		cyc(1'b0, 1'b0, m);
		for (int i = 0; i < 64; i++) begin
			cyc(1'b1, pat[i], m);
			if (m !== 1'b0) ok = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the hidden timekeeper gate
// Assumes: Short tick parameter, AXI master changes signals after edges
// Notes:   Read and write answers are checked off a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [63:0] PAT  = 64'h0123_4567_89AB_CDEF;
	localparam int          TICK = 64;
	localparam hrc_pkg::hrc_time_t E5 = '{year: 7'd1, month: 4'd1,
		date: 5'd5, dow: 3'd1, pm: 1'b1, hour: 5'd12, default: '0};
	logic [63:0] rd;
	logic        clk, rst_n, pf, rom, dq, dq_oe, mem_n, h_ce, h_oe, h_we, h_d0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, m, ok;
	logic [63:0] expq[$];
	logic [63:0] mon_e;
	int          fail_count, tests_run, seed;
	wire         d0_w = dq_oe ? dq : h_d0;

	hrc_gate #(.PATTERN(PAT), .TICK_CYCLES(TICK)) uut (
		.i_sys_clk(clk), .i_arst_n(rst_n),
		.i_host_chip_enable_in_n(h_ce), .i_oe_n(h_oe), .i_we_n(h_we),
		.i_data_bit_zero(d0_w), .o_data_bit_zero(dq),
		.o_data_bit_zero_oe(dq_oe), .o_memory_chip_enable_out_n(mem_n),
		.i_power_fail(pf), .i_rom_mode(rom),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	hrc_host_mdl host (.i_sys_clk(clk), .i_mem_n(mem_n), .i_d0(d0_w),
		.o_ce_n(h_ce), .o_oe_n(h_oe), .o_we_n(h_we), .o_d0(h_d0));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Compare, verdict, watchdog
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string nm);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict;
		$display("Checks run %0d, errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		print_verdict;
	end

	always @(posedge clk) begin
		if (rvalid && rready && expq.size() > 0) begin
			mon_e = expq.pop_front();
			chk(rdata & mon_e[63:32], mon_e[31:0], "rdata");
		end
		if (bvalid && bready && expq.size() > 0) begin
			mon_e = expq.pop_front();
			chk({30'h0, bresp}, mon_e[31:0], "bresp");
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite master
	// ------------------------------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		expq.push_back({32'h0000_0003, 30'h0, er});
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] msk,
		input logic [31:0] exp);
		expq.push_back({msk, exp});
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// ------------------------------------------------------------
	// Unlock, then 64 window writes; pfw raises ROM power fail first
	// ------------------------------------------------------------
	task automatic load(input hrc_pkg::hrc_time_t t, input logic pfw);
		logic [63:0] w;
		logic        okw;
		w   = 64'(t);
		okw = 1'b1;
		host.unlock(PAT, ok);
		chk({31'h0, ok}, 32'h0000_0001, "pass_mem");
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0400, 32'h0000_0400);
		if (pfw) begin
			pf  <= 1'b1;
			rom <= 1'b1;
			repeat (10) @(posedge clk);
		end
		for (int i = 0; i < 64; i++) begin
			host.cyc(1'b1, w[i], m);
			if (m !== !pfw) okw = 1'b0;
		end
		chk({31'h0, okw}, 32'h0000_0001, "window_mem");
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0400, 32'h0000_0000);
	endtask

	// Table of rollover starts and expected results
	int yr[6]  = '{1, 4, 4, 1, 1, 1};
	int mo[6]  = '{2, 2, 2, 4, 12, 1};
	int dt[6]  = '{28, 28, 29, 30, 31, 5};
	int eyr[6] = '{1, 4, 4, 1, 2, 1};
	int emo[6] = '{3, 2, 3, 5, 1, 1};
	int edt[6] = '{1, 29, 1, 1, 1, 5};

	task automatic roll(input int i);
		hrc_pkg::hrc_time_t s;
		hrc_pkg::hrc_time_t e;
		logic [63:0]        ew;
		s = '{year: 7'(yr[i]), month: 4'(mo[i]), date: 5'(dt[i]), dow: 3'd1,
			pm: 1'b0, hour: (i == 5) ? 5'd11 : 5'd23, minute: 6'd59,
			second: 6'd59, hundredth: 7'd99};
		e = '{year: 7'(eyr[i]), month: 4'(emo[i]), date: 5'(edt[i]),
			dow: (i == 5) ? 3'd1 : 3'd2, pm: (i == 5), hour: (i == 5) ? 5'd12 : 5'd0,
			minute: 6'd0, second: 6'd0, hundredth: 7'd0};
		ew = 64'(e);
		load(s, 1'b0);
		repeat (2 * TICK) @(posedge clk);
		axr(hrc_pkg::HRC_OFS_TIME0, 32'hFFFF_FF80, ew[31:0]);
		axr(hrc_pkg::HRC_OFS_TIME1, 32'h0FFF_FFFF, ew[63:32]);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 33501;
		{rst_n, pf, rom, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		axr(hrc_pkg::HRC_OFS_CTRL, 32'h0000_0001, 32'h0000_0000);
		axw(8'h10 + 8'({$random(seed)} % 60) * 8'h04, 32'h0000_0001,
			hrc_pkg::HRC_RESP_SLVERR);
		axw(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0000, hrc_pkg::HRC_RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			host.cyc(1'($random(seed)), 1'($random(seed)), m);
			chk({31'h0, m}, 32'h0000_0000, "follow");
		end
		host.cyc(1'b0, 1'b0, m);
		for (int i = 0; i < 5; i++) host.cyc(1'b1, PAT[i], m);
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0C7F, 32'h0000_0005);
		host.cyc(1'b1, !PAT[5], m);
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0C7F, 32'h0000_0805);
		host.cyc(1'b1, PAT[5], m);
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0C7F, 32'h0000_0805);
		host.cyc(1'b0, 1'b0, m);
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0C7F, 32'h0000_0000);
		for (int i = 0; i < 5; i++) roll(i);
		load('{year: 7'd9, month: 4'd7, date: 5'd3, default: '0}, 1'b1);
		axr(hrc_pkg::HRC_OFS_STATUS, 32'h0000_0300, 32'h0000_0300);
		host.cyc(1'b0, 1'b0, m);
		chk({31'h0, m}, 32'h0000_0000, "rom_pfail");
		rom <= 1'b0;
		repeat (10) @(posedge clk);
		host.cyc(1'b1, 1'b0, m);
		chk({31'h0, m}, 32'h0000_0001, "ram_pfail");
		axw(hrc_pkg::HRC_OFS_TIME1, 32'h0000_0062, hrc_pkg::HRC_RESP_OKAY);
		pf <= 1'b0;
		repeat (10) @(posedge clk);
		axr(hrc_pkg::HRC_OFS_TIME1, 32'h0000_0FFE, 32'h0000_0042);
		axw(hrc_pkg::HRC_OFS_TIME1, 32'h0000_0062, hrc_pkg::HRC_RESP_OKAY);
		axr(hrc_pkg::HRC_OFS_TIME1, 32'h0000_0FFE, 32'h0000_0062);
		axw(hrc_pkg::HRC_OFS_CTRL, 32'h0000_0001, hrc_pkg::HRC_RESP_OKAY);
		roll(5);
		host.unlock(PAT, ok);
		for (int i = 0; i < 64; i++) begin
			host.cyc(1'b0, 1'b0, m);
			rd[i] = host.q;
		end
		chk(rd[43:12], E5[43:12], "serial_read");
		print_verdict;
	end
endmodule
`default_nettype wire

// ===== verilog/hrc_gate.sv
// Purpose: Hidden timekeeper behind a memory chip enable
// Assumes: Host strobes active low, one pin cycle per chip enable low
// Notes:   Calendar readable over AXI4-Lite; TIME1 writes load only year, month and date MSB
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
`timescale 1ns/1ps
// Function
// - Timekeeper opens only after the full 64-bit unlock pattern
// - Idle timekeeper passes host chip enable to memory under normal supply
// - Count hundredths, seconds, minutes, hours, weekday, date, month, year
// - Date rolls at the true last day of each month
// - February gains a day every fourth year
// - Hours count in 12-hour with PM flag or 24-hour format
// - RAM mode power fail holds memory enable inactive
// - Normal supply: memory enable follows host except during access
// - Mode pin high selects ROM, low selects RAM
// - ROM mode power fail drives memory enable low
// - Power fail write-protects timekeeper in both modes, clock runs
// - Any read outside the access window returns the compare pointer to bit zero
// - Writes compare bit zero; mismatch locks until a read
// - After match, 64 cycles move timekeeper bits, memory disabled except in ROM mode power fail
module hrc_gate #(
	parameter logic [63:0] PATTERN     = 64'hA5A5_5A5A_C3C3_3C3C,
	parameter int          TICK_CYCLES = hrc_pkg::HRC_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	// Host memory pins
	input  wire logic        i_host_chip_enable_in_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_data_bit_zero,
	output logic             o_data_bit_zero,
	output logic             o_data_bit_zero_oe,
	output logic             o_memory_chip_enable_out_n,
	// Supply and mode
	input  wire logic        i_power_fail,
	input  wire logic        i_rom_mode,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	hrc_pkg::hrc_host_t host_raw;
	hrc_pkg::hrc_host_t host;
	logic [1:0]         sup;
	logic               pfail;
	logic               rom;

	assign host_raw = '{ce_n: i_host_chip_enable_in_n, oe_n: i_oe_n,
		we_n: i_we_n, d0: i_data_bit_zero};

	hrc_sync #(.WIDTH(4), .INIT(4'hE)) u_sync_host (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_async   (host_raw),
		.o_sync    (host)
	);
	hrc_sync #(.WIDTH(2), .INIT(2'h0)) u_sync_sup (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_async   ({i_power_fail, i_rom_mode}),
		.o_sync    (sup)
	);
	assign pfail = sup[1];
	assign rom   = sup[0];

	// ------------------------------------------------------------
	// Cycle detection
	// ------------------------------------------------------------
	logic ce_d_r;
	logic cyc_end;
	logic was_rd_r;
	logic was_wr_r;
	logic d0_r;
	logic rd_end;
	logic wr_end;

	assign cyc_end = ~ce_d_r & host.ce_n;
	assign rd_end  = cyc_end & was_rd_r;
	assign wr_end  = cyc_end & was_wr_r;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ce_d_r   <= 1'b1;
			was_rd_r <= 1'b0;
			was_wr_r <= 1'b0;
			d0_r     <= 1'b0;
		end else begin
			ce_d_r <= host.ce_n;
			if (!host.ce_n) begin
				was_rd_r <= ~host.oe_n & host.we_n;
				was_wr_r <= ~host.we_n;
				d0_r     <= host.d0;
			end
		end
	end

	// ------------------------------------------------------------
	// Pattern match and access window
	// ------------------------------------------------------------
	logic [6:0]  ptr_r;
	logic        lock_r;
	logic        open_r;
	logic [5:0]  xcnt_r;
	logic [63:0] shift_r;
	logic        pat_hit;
	logic        last_pat;
	logic        last_xfer;

	assign pat_hit   = d0_r == PATTERN[ptr_r[5:0]];
	assign last_pat  = ptr_r == 7'(hrc_pkg::HRC_PAT_BITS - 1);
	assign last_xfer = xcnt_r == 6'(hrc_pkg::HRC_XFER_CYCLES - 1);

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ptr_r  <= 7'h00;
			lock_r <= 1'b0;
			open_r <= 1'b0;
			xcnt_r <= 6'h00;
		end else if (open_r && cyc_end) begin
			xcnt_r <= xcnt_r + 6'd1;
			if (last_xfer) begin
				open_r <= 1'b0;
				ptr_r  <= 7'h00;
				lock_r <= 1'b0;
			end
		end else if (!open_r && rd_end) begin
			ptr_r  <= 7'h00;
			lock_r <= 1'b0;
		end else if (!open_r && wr_end && !lock_r) begin
			if (!pat_hit)
				lock_r <= 1'b1;
			else if (last_pat) begin
				open_r <= 1'b1;
				xcnt_r <= 6'h00;
			end else
				ptr_r <= ptr_r + 7'd1;
		end
	end

	// ------------------------------------------------------------
	// Calendar
	// ------------------------------------------------------------
	hrc_pkg::hrc_time_t tm_r;
	logic [31:0]        tick_r;
	logic               tick;
	logic [4:0]         mdays;
	logic               leap;
	logic               h12_r;
	logic [4:0]         hmax;
	logic [4:0]         hmin;
	logic               c_hu;
	logic               c_se;
	logic               c_mi;
	logic               c_hr;
	logic               c_da;
	logic               c_mo;
	logic               xfer_done;
	logic               sw_load;
	hrc_pkg::hrc_time_t sw_time;

	assign tick = tick_r == 32'(TICK_CYCLES - 1);
	assign leap = tm_r.year[1:0] == 2'b00;
	assign hmax = h12_r ? hrc_pkg::HRC_HR12_MAX : hrc_pkg::HRC_HR24_MAX;
	assign hmin = h12_r ? 5'd1 : 5'd0;

	always_comb begin
		unique case (tm_r.month)
			4'd4, 4'd6, 4'd9, 4'd11: mdays = 5'd30;
			hrc_pkg::HRC_FEB:        mdays = leap ? 5'd29 : 5'd28;
			default:                 mdays = 5'd31;
		endcase
	end

	assign c_hu = tick & (tm_r.hundredth == hrc_pkg::HRC_HUND_MAX);
	assign c_se = c_hu & (tm_r.second == hrc_pkg::HRC_MIN_MAX);
	assign c_mi = c_se & (tm_r.minute == hrc_pkg::HRC_MIN_MAX);
	assign c_hr = c_mi & (h12_r ? (tm_r.hour == 5'd11 && tm_r.pm)
		: tm_r.hour == hrc_pkg::HRC_HR24_MAX);
	assign c_da = c_hr & (tm_r.date == mdays);
	assign c_mo = c_da & (tm_r.month == hrc_pkg::HRC_MON_MAX);
	// Clock write-protect in power fail, both memory modes
	assign xfer_done = open_r & cyc_end & last_xfer & was_wr_r & ~pfail;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_r <= 32'h0000_0000;
			tm_r   <= '{year: 7'd0, month: 4'd1, date: 5'd1, dow: 3'd1,
				pm: 1'b0, hour: 5'd0, minute: 6'd0, second: 6'd0,
				hundredth: 7'd0};
		end else begin
			tick_r <= tick ? 32'h0000_0000 : tick_r + 32'd1;
			if (xfer_done)
				tm_r <= shift_r[44:1];
			else if (sw_load && !pfail)
				tm_r <= sw_time;
			else if (tick) begin
				tm_r.hundredth <= c_hu ? 7'd0 : tm_r.hundredth + 7'd1;
				if (c_hu)
					tm_r.second <= c_se ? 6'd0 : tm_r.second + 6'd1;
				if (c_se)
					tm_r.minute <= c_mi ? 6'd0 : tm_r.minute + 6'd1;
				if (c_mi) begin
					if (h12_r && tm_r.hour == 5'd11)
						tm_r.pm <= ~tm_r.pm;
					if (tm_r.hour == hmax)
						tm_r.hour <= hmin;
					else
						tm_r.hour <= tm_r.hour + 5'd1;
				end
				if (c_hr) begin
					tm_r.dow  <= (tm_r.dow == hrc_pkg::HRC_DOW_MAX) ? 3'd1
						: tm_r.dow + 3'd1;
					tm_r.date <= c_da ? 5'd1 : tm_r.date + 5'd1;
				end
				if (c_da)
					tm_r.month <= c_mo ? 4'd1 : tm_r.month + 4'd1;
				if (c_mo)
					tm_r.year <= (tm_r.year == hrc_pkg::HRC_YEAR_MAX) ? 7'd0
						: tm_r.year + 7'd1;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial transfer shifter
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			shift_r <= 64'h0000_0000_0000_0000;
		else if (!open_r)
			shift_r <= 64'(tm_r);
		else if (cyc_end)
			shift_r <= {(was_wr_r ? d0_r : shift_r[0]), shift_r[63:1]};
	end

	// ------------------------------------------------------------
	// Pin outputs
	// ------------------------------------------------------------
	logic ceo_nxt;
	logic dq_oe_nxt;

	always_comb begin
		if (pfail)
			ceo_nxt = rom ? 1'b0 : 1'b1;
		else if (open_r)
			ceo_nxt = 1'b1;
		else
			ceo_nxt = host.ce_n;
	end
	assign dq_oe_nxt = open_r & ~host.ce_n & ~host.oe_n & host.we_n;

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_memory_chip_enable_out_n <= 1'b1;
			o_data_bit_zero            <= 1'b0;
			o_data_bit_zero_oe         <= 1'b0;
		end else begin
			o_memory_chip_enable_out_n <= ceo_nxt;
			o_data_bit_zero            <= shift_r[0];
			o_data_bit_zero_oe         <= dq_oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic        aw_r;
	logic        w_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        do_wr;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_mux;
	logic [59:0] time_bits;

	assign time_bits = 60'(tm_r);
	assign do_wr = aw_r & w_r & ~s_axi_bvalid;
	assign wr_ok = awaddr_r == hrc_pkg::HRC_OFS_CTRL
		|| awaddr_r == hrc_pkg::HRC_OFS_TIME0
		|| awaddr_r == hrc_pkg::HRC_OFS_TIME1;
	assign rd_ok = wr_ok_rd(s_axi_araddr);
	assign sw_time = {wdata_r[11:0], time_bits[31:0]};
	assign sw_load = do_wr & wstrb_r[0] & (awaddr_r == hrc_pkg::HRC_OFS_TIME1);

	function automatic logic wr_ok_rd(input logic [7:0] a);
		wr_ok_rd = a == hrc_pkg::HRC_OFS_CTRL || a == hrc_pkg::HRC_OFS_STATUS
			|| a == hrc_pkg::HRC_OFS_TIME0 || a == hrc_pkg::HRC_OFS_TIME1;
	endfunction

	always_comb begin
		unique case (s_axi_araddr)
			hrc_pkg::HRC_OFS_CTRL:   rd_mux = {31'h0, h12_r};
			hrc_pkg::HRC_OFS_STATUS: rd_mux = {20'h0, lock_r, open_r,
				rom, pfail, 1'b0, ptr_r};
			hrc_pkg::HRC_OFS_TIME0:  rd_mux = time_bits[31:0];
			hrc_pkg::HRC_OFS_TIME1:  rd_mux = {4'h0, time_bits[59:32]};
			default:                 rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_r          <= 1'b0;
			w_r           <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			h12_r         <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= hrc_pkg::HRC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= hrc_pkg::HRC_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_r & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_r & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r     <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_r     <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_r         <= 1'b0;
				w_r          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? hrc_pkg::HRC_RESP_OKAY
					: hrc_pkg::HRC_RESP_SLVERR;
				if (awaddr_r == hrc_pkg::HRC_OFS_CTRL && wstrb_r[0])
					h12_r <= wdata_r[hrc_pkg::HRC_CTRL_H12];
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_ok ? hrc_pkg::HRC_RESP_OKAY
					: hrc_pkg::HRC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence pf_ram_s;
		pfail && !rom;
	endsequence
	sequence pf_rom_s;
		pfail && rom;
	endsequence

	ram_protect_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) pf_ram_s |=> o_memory_chip_enable_out_n)
		else $error("Memory enable active during RAM power fail");
	rom_force_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) pf_rom_s |=> !o_memory_chip_enable_out_n)
		else $error("Memory enable not low during ROM power fail");
	pass_through_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (!pfail && !open_r)
		|=> o_memory_chip_enable_out_n == $past(host.ce_n))
		else $error("Memory enable does not follow host enable");
	open_block_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (open_r && !pfail)
		|=> o_memory_chip_enable_out_n)
		else $error("Memory enabled during timekeeper access");
	read_reset_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (rd_end && !open_r)
		|=> ptr_r == 7'h00 && !lock_r)
		else $error("Read did not reset compare pointer");
	miss_lock_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (wr_end && !open_r && !lock_r && !pat_hit)
		|=> lock_r && $stable(ptr_r))
		else $error("Mismatch did not lock compare");
	unlock_only_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) $rose(open_r)
		|-> $past(ptr_r) == 7'(hrc_pkg::HRC_PAT_BITS - 1))
		else $error("Access opened before full pattern");
	hour_range_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (h12_r && tick && !sw_load && !xfer_done
		&& tm_r.hour >= 5'd1) |=> tm_r.hour <= hrc_pkg::HRC_HR12_MAX)
		else $error("Hour out of 12-hour range");
	feb_roll_a: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) (c_hr && !xfer_done && !sw_load
		&& tm_r.month == hrc_pkg::HRC_FEB && tm_r.date == 5'd28 && leap)
		|=> tm_r.date == 5'd29)
		else $error("Leap February skipped its last day");
endmodule
`default_nettype wire

// ===== verilog/hrc_pkg.sv
// Purpose: Shared constants and types for the hidden timekeeper gate
// Assumes: 50 MHz system clock, host bus strobes are active low pins
// Notes:   Binary calendar fields, register window offsets
`default_nettype none
package hrc_pkg;
	// ------------------------------------------------------------
	// Bus map
	// ------------------------------------------------------------
	localparam logic [7:0] HRC_OFS_CTRL   = 8'h00;
	localparam logic [7:0] HRC_OFS_STATUS = 8'h04;
	localparam logic [7:0] HRC_OFS_TIME0  = 8'h08;
	localparam logic [7:0] HRC_OFS_TIME1  = 8'h0C;
	localparam logic [1:0] HRC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] HRC_RESP_SLVERR = 2'b10;
	localparam int         HRC_CTRL_H12    = 0;
	localparam int         HRC_CTRL_LOAD   = 1;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int HRC_CLK_HZ      = 50_000_000;
	localparam int HRC_TICK_HZ     = 100;
	localparam int HRC_TICK_CYCLES = HRC_CLK_HZ / HRC_TICK_HZ;
	localparam int HRC_PAT_BITS    = 64;
	localparam int HRC_XFER_CYCLES = 64;
	// ------------------------------------------------------------
	// Calendar limits
	// ------------------------------------------------------------
	localparam logic [6:0] HRC_HUND_MAX = 7'd99;
	localparam logic [5:0] HRC_MIN_MAX  = 6'd59;
	localparam logic [4:0] HRC_HR24_MAX = 5'd23;
	localparam logic [4:0] HRC_HR12_MAX = 5'd12;
	localparam logic [2:0] HRC_DOW_MAX  = 3'd7;
	localparam logic [3:0] HRC_MON_MAX  = 4'd12;
	localparam logic [3:0] HRC_FEB      = 4'd2;
	localparam logic [6:0] HRC_YEAR_MAX = 7'd99;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] date;
		logic [2:0] dow;
		logic       pm;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
		logic [6:0] hundredth;
	} hrc_time_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic d0;
	} hrc_host_t;
endpackage
`default_nettype wire

// ===== verilog/hrc_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input asynchronous to i_sys_clk
// Notes:   Output changes once stages two and three agree
`default_nettype none
`timescale 1ns/1ps
module hrc_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_arst_n,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_r   <= INIT;
			s2_r   <= INIT;
			s3_r   <= INIT;
			o_sync <= INIT;
		end else begin
			s1_r   <= i_async;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			o_sync <= (agree & s3_r) | (~agree & o_sync);
		end
	end
endmodule
`default_nettype wire
